// [rtl/lbfuc_pkg.sv]
// Purpose: constants for the lin break field control block
// Assumes: 8-bit registers on a 16-bit byte address bus
// Notes:   field positions are bit indices within each register
//
// Overview of operation
// - reset loads the lin break control register with 16H
// - break rx flag reads 1 during reception, 0 when off or received
// - writing 1 to the rx trigger starts break reception; reads as 0
// - rx trigger clears itself after a correctly received break
// - after a reception error the flag stays 1; software rearms
// - writing 1 to tx trigger sends a break; reads 0, self clears
// - three-bit length field selects 13 to 20 bit break length
// - first bit select gives msb first at 0, lsb first at 1
// - tx invert bit gives normal output at 0, inverted at 1
// - capture source select picks own pin at 0, serial rx at 1
// - irq0 source select picks own pin at 0, serial rx at 1
// - input route register resets to 00H
// - port 4 direction 0 enables output buffer, 1 makes input
// - port 4 direction register resets to FFH
// - power off resets break rx flag and rx trigger
package lbfuc_pkg;
   // register byte addresses
   localparam logic [15:0] OFS_PORT4_DIR   = 16'hFF24;
   localparam logic [15:0] OFS_BREAK_CTRL  = 16'hFF98;
   localparam logic [15:0] OFS_INPUT_ROUTE = 16'hFF8C;
   // reset values
   localparam logic [7:0]  RST_PORT4_DIR   = 8'hFF;
   localparam logic [7:0]  RST_BREAK_CTRL  = 8'h16;
   localparam logic [7:0]  RST_INPUT_ROUTE = 8'h00;
   // break control fields
   localparam int BIT_RX_FLAG  = 7;
   localparam int BIT_RX_TRIG  = 6;
   localparam int BIT_TX_TRIG  = 5;
   localparam int LEN_MSB      = 4;
   localparam int LEN_LSB      = 2;
   localparam int BIT_FIRST    = 1;
   localparam int BIT_INVERT   = 0;
   // input route fields
   localparam int BIT_IRQ0_SEL = 0;
   localparam int BIT_CAP_SEL  = 1;
   // timing counts in bit periods, and the highest length code that counts up from the base
   localparam logic [4:0] BREAK_LEN_BASE    = 5'h10;
   localparam logic [4:0] BREAK_LEN_WRAP    = 5'h08;
   localparam logic [2:0] BREAK_SEL_MAX_UP  = 3'h4;
   localparam logic [4:0] RX_BREAK_MIN_BITS = 5'h0B;

   typedef enum logic [2:0] {
      RX_IDLE = 3'b001,
      RX_WAIT = 3'b010,
      RX_LOW  = 3'b100
   } lbfuc_rx_state_type;

   // length code to bit periods: 000..100 -> 16..20, 101..111 -> 13..15
   function automatic logic [4:0] break_len_bits(input logic [2:0] sel);
      if (sel <= BREAK_SEL_MAX_UP) begin
         break_len_bits = BREAK_LEN_BASE + {2'b00, sel};
      end else begin
         break_len_bits = BREAK_LEN_WRAP + {2'b00, sel};
      end
   endfunction
endpackage

// [rtl/lbfuc_break_timer.sv]
// Purpose: counts whole bit periods of a transmitted break field
// Assumes: tick_in pulses once per bit period on the same clock
// Notes:   abort wins over start; done pulses one cycle
`timescale 1ns/1ps
module lbfuc_break_timer
   import lbfuc_pkg::*;
#(
   parameter int LEN_W = 5
) (
   // clock and reset
   input  wire logic             clk_sys_in,
   input  wire logic             sys_rst_in,
   input  wire logic             clk_en_in,
   // control
   input  wire logic             start_in,
   input  wire logic             abort_in,
   input  wire logic             tick_in,
   input  wire logic [LEN_W-1:0] len_in,
   // status
   output logic                  busy_out,
   output logic                  done_out
);
   logic [LEN_W-1:0] cnt_reg;

   ////////////////////////////////////////////////////////////////////
   // break period counter
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         busy_out <= 1'b0;
         done_out <= 1'b0;
         cnt_reg  <= '0;
      end else if (clk_en_in) begin
         done_out <= 1'b0;
         if (abort_in) begin
            busy_out <= 1'b0;
         end else if (start_in) begin
            busy_out <= 1'b1;
            cnt_reg  <= len_in;
         end else if (busy_out && tick_in) begin
            if (cnt_reg == LEN_W'(1)) begin
               busy_out <= 1'b0;
               done_out <= 1'b1;
            end else begin
               cnt_reg <= cnt_reg - LEN_W'(1);
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);

   a_start_loads_len: assert property (
      (clk_en_in && start_in && !abort_in) |=> busy_out && cnt_reg == $past(len_in))
      else $error("break length not loaded on start");
   a_done_ends_busy: assert property (
      (done_out && $past(clk_en_in))
      |-> !busy_out && $past(busy_out) && $past(cnt_reg) == LEN_W'(1))
      else $error("break ended at wrong count");
endmodule

// [rtl/lbfuc_ctrl.sv]
// Purpose: lin break field control, input routing and port 4 direction
// Assumes: mode bits, baud tick and frame bit come from same-clock logic
// Notes:   serial rx and routed pins are synchronised by two flops
`timescale 1ns/1ps
module lbfuc_ctrl
   import lbfuc_pkg::*;
(
   // clock, reset, enable
   input  wire logic        clk_sys_in,
   input  wire logic        sys_rst_in,
   input  wire logic        clk_en_in,
   // register access
   input  wire logic [15:0] reg_addr_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   input  wire logic [7:0]  reg_wdata_in,
   output logic      [7:0]  reg_rdata_out,
   // serial unit mode and frame engine
   input  wire logic        unit_power_in,
   input  wire logic        tx_enable_bit_in,
   input  wire logic        rx_enable_bit_in,
   input  wire logic        baud_tick_in,
   input  wire logic        tx_frame_bit_in,
   // pins
   input  wire logic        serial_in_pin_in,
   input  wire logic        irq0_pin_in,
   input  wire logic        capture_pin_in,
   output logic             serial_out_pin_out,
   output logic      [7:0]  port4_oe_out,
   // routed inputs and status
   output logic             ext_irq0_input_out,
   output logic             timer_capture_input_out,
   output logic             first_bit_sel_out,
   output logic             break_tx_busy_out,
   output logic             break_tx_done_out,
   output logic             break_rx_done_out,
   output logic             break_rx_error_out
);
   logic [2:0]         pin_meta_reg;
   logic [2:0]         pin_sync_reg;
   logic [2:0]         break_len_reg;
   logic               tx_invert_reg;
   logic [1:0]         route_reg;
   logic [7:0]         port4_dir_reg;
   logic               rx_flag_reg;
   logic               rx_trig_reg;
   logic [4:0]         rx_cnt_reg;
   lbfuc_rx_state_type rx_state_reg;
   logic               rx_line;
   logic               ctrl_wr;
   logic               tx_start;
   logic               tx_abort;
   logic               rx_start;
   logic [4:0]         tx_len;

   ////////////////////////////////////////////////////////////////////
   // decode and line conditioning
   assign ctrl_wr  = reg_wr_in && reg_addr_in == OFS_BREAK_CTRL;
   // rx is held high while the unit is powered down
   assign rx_line  = unit_power_in ? pin_sync_reg[0] : 1'b1;
   // a refresh with both triggers zero starts nothing
   assign tx_start = ctrl_wr && reg_wdata_in[BIT_TX_TRIG]
                     && unit_power_in && tx_enable_bit_in;
   assign tx_abort = !unit_power_in || !tx_enable_bit_in;
   assign rx_start = ctrl_wr && reg_wdata_in[BIT_RX_TRIG]
                     && unit_power_in && rx_enable_bit_in;
   // a triggering write carries the length that its break uses
   assign tx_len   = break_len_bits(reg_wdata_in[LEN_MSB:LEN_LSB]);

   ////////////////////////////////////////////////////////////////////
   // two-flop synchronisers: 0 serial rx, 1 irq0 pin, 2 capture pin
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         pin_meta_reg <= 3'h7;
         pin_sync_reg <= 3'h7;
      end else if (clk_en_in) begin
         pin_meta_reg <= {capture_pin_in, irq0_pin_in, serial_in_pin_in};
         pin_sync_reg <= pin_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // writable fields of the control, route and direction registers
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         break_len_reg     <= RST_BREAK_CTRL[LEN_MSB:LEN_LSB];
         first_bit_sel_out <= RST_BREAK_CTRL[BIT_FIRST];
         tx_invert_reg     <= RST_BREAK_CTRL[BIT_INVERT];
         route_reg         <= RST_INPUT_ROUTE[1:0];
         port4_dir_reg     <= RST_PORT4_DIR;
      end else if (clk_en_in && reg_wr_in) begin
         if (reg_addr_in == OFS_BREAK_CTRL) begin
            break_len_reg     <= reg_wdata_in[LEN_MSB:LEN_LSB];
            // order and level are written on any write, whatever the tx and rx enables
            first_bit_sel_out <= reg_wdata_in[BIT_FIRST];
            tx_invert_reg     <= reg_wdata_in[BIT_INVERT];
         end
         if (reg_addr_in == OFS_INPUT_ROUTE) begin
            route_reg <= {reg_wdata_in[BIT_CAP_SEL],
                          reg_wdata_in[BIT_IRQ0_SEL]};
         end
         if (reg_addr_in == OFS_PORT4_DIR) begin
            port4_dir_reg <= reg_wdata_in;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // break reception: flag, trigger and low-level measurement
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         rx_state_reg       <= RX_IDLE;
         rx_flag_reg        <= 1'b0;
         rx_trig_reg        <= 1'b0;
         rx_cnt_reg         <= 5'h00;
         break_rx_done_out  <= 1'b0;
         break_rx_error_out <= 1'b0;
      end else if (clk_en_in) begin
         break_rx_done_out  <= 1'b0;
         break_rx_error_out <= 1'b0;
         if (!unit_power_in) begin
            rx_flag_reg  <= 1'b0;
            rx_trig_reg  <= 1'b0;
            rx_state_reg <= RX_IDLE;
         end else if (rx_start) begin
            // a new trigger wins over any ending in the same cycle
            rx_flag_reg  <= 1'b1;
            rx_trig_reg  <= 1'b1;
            rx_state_reg <= RX_WAIT;
         end else if (!rx_enable_bit_in) begin
            rx_trig_reg  <= 1'b0;
            rx_state_reg <= RX_IDLE;
         end else begin
            unique case (rx_state_reg)
               RX_IDLE: begin
                  rx_state_reg <= RX_IDLE;
               end
               RX_WAIT: begin
                  rx_cnt_reg <= 5'h00;
                  if (!rx_line) begin
                     rx_state_reg <= RX_LOW;
                  end
               end
               RX_LOW: begin
                  if (rx_line) begin
                     rx_trig_reg  <= 1'b0;
                     rx_state_reg <= RX_IDLE;
                     if (rx_cnt_reg >= RX_BREAK_MIN_BITS) begin
                        rx_flag_reg       <= 1'b0;
                        break_rx_done_out <= 1'b1;
                     end else begin
                        // flag stays set; software rearms
                        break_rx_error_out <= 1'b1;
                     end
                  end else if (baud_tick_in && rx_cnt_reg != 5'h1F) begin
                     rx_cnt_reg <= rx_cnt_reg + 5'h01;
                  end
               end
               default: begin
                  rx_state_reg <= RX_IDLE;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // break transmission timer
   lbfuc_break_timer #(
      .LEN_W (5)
   ) u_break_timer (
      .clk_sys_in (clk_sys_in),
      .sys_rst_in (sys_rst_in),
      .clk_en_in  (clk_en_in),
      .start_in   (tx_start),
      .abort_in   (tx_abort),
      .tick_in    (baud_tick_in),
      .len_in     (tx_len),
      .busy_out   (break_tx_busy_out),
      .done_out   (break_tx_done_out)
   );

   ////////////////////////////////////////////////////////////////////
   // pin outputs and routed inputs
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         serial_out_pin_out      <= 1'b1;
         port4_oe_out            <= ~RST_PORT4_DIR;
         ext_irq0_input_out      <= 1'b1;
         timer_capture_input_out <= 1'b1;
      end else if (clk_en_in) begin
         if (!unit_power_in) begin
            serial_out_pin_out <= 1'b1;
         end else begin
            // break forces low, or high when tx invert is set, then the frame bit resumes
            serial_out_pin_out <= (tx_frame_bit_in && !break_tx_busy_out)
                                  ^ tx_invert_reg;
         end
         // pin latch high and direction 0 are set by software
         port4_oe_out <= ~port4_dir_reg;
         // routed inputs take the rx pin itself, powered or not
         ext_irq0_input_out <= route_reg[0] ? pin_sync_reg[0]
                                            : pin_sync_reg[1];
         timer_capture_input_out <= route_reg[1] ? pin_sync_reg[0]
                                                 : pin_sync_reg[2];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // register read data, triggers always read as zero
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         reg_rdata_out <= 8'h00;
      end else if (clk_en_in && reg_rd_in) begin
         unique case (reg_addr_in)
            OFS_BREAK_CTRL:  reg_rdata_out <= {rx_flag_reg, 2'b00,
                                              break_len_reg,
                                              first_bit_sel_out,
                                              tx_invert_reg};
            OFS_INPUT_ROUTE: reg_rdata_out <= {6'h00, route_reg};
            OFS_PORT4_DIR:   reg_rdata_out <= port4_dir_reg;
            default:         reg_rdata_out <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);

   a_ctrl_reset_value: assert property (
      $fell(sys_rst_in) |-> break_len_reg == 3'h5 && first_bit_sel_out
                            && !tx_invert_reg && !rx_flag_reg)
      else $error("control register reset value wrong");
   a_route_reset_zero: assert property (
      $fell(sys_rst_in) |-> route_reg == 2'h0)
      else $error("route register reset value wrong");
   a_port_dir_reset: assert property (
      $fell(sys_rst_in) |-> port4_oe_out == 8'h00 && port4_dir_reg == 8'hFF)
      else $error("port direction reset value wrong");
   a_rx_trig_flag: assert property (
      (clk_en_in && rx_start) |=> rx_flag_reg && rx_state_reg == RX_WAIT)
      else $error("break reception did not start");
   a_trig_read_zero: assert property (
      (clk_en_in && reg_rd_in && reg_addr_in == OFS_BREAK_CTRL)
      |=> reg_rdata_out[6:5] == 2'h0 && reg_rdata_out[7] == $past(rx_flag_reg))
      else $error("trigger bits read back nonzero");
   a_rx_done_clear: assert property (
      break_rx_done_out |-> !rx_flag_reg && !rx_trig_reg
                            && $past(rx_cnt_reg) >= RX_BREAK_MIN_BITS)
      else $error("rx trigger or flag not cleared on success");
   a_rx_error_hold: assert property (
      break_rx_error_out |-> rx_flag_reg ##1 (rx_flag_reg || !unit_power_in
                                              || $past(rx_start)))
      else $error("flag not held after reception error");
   a_power_off_clr: assert property (
      (clk_en_in && !unit_power_in) |=> !rx_flag_reg && !rx_trig_reg)
      else $error("power off did not clear reception state");
   a_tx_invert_out: assert property (
      (clk_en_in && unit_power_in) |=> serial_out_pin_out ==
         (($past(tx_frame_bit_in) && !$past(break_tx_busy_out))
          ^ $past(tx_invert_reg)))
      else $error("serial output level wrong");
   a_capture_route: assert property (
      clk_en_in |=> timer_capture_input_out == ($past(route_reg[1])
         ? $past(pin_sync_reg[0]) : $past(pin_sync_reg[2])))
      else $error("capture input routed wrongly");
   a_irq0_route: assert property (
      clk_en_in |=> ext_irq0_input_out == ($past(route_reg[0])
         ? $past(pin_sync_reg[0]) : $past(pin_sync_reg[1])))
      else $error("irq0 input routed wrongly");

   c_rx_success: cover property (break_rx_done_out);
   c_rx_error:   cover property (break_rx_error_out);
   c_tx_break:   cover property (break_tx_busy_out ##1 break_tx_done_out);
endmodule

// [dv/lbfuc_lin_node.sv]
// Purpose: lin node model facing the serial pins of the block
// Assumes: one-cycle baud tick per bit period on the system clock
// Notes:   line idles high, as the lin bus pull-up holds it
`timescale 1ns/1ps
module lbfuc_lin_node (
   // clock and bit timing
   input  wire logic clk_sys_in,
   input  wire logic baud_tick_in,
   // serial pins
   input  wire logic serial_out_pin_in,
   output logic      serial_in_pin_out
);
   ////////////////////////////////////////////////////////////////////
   logic       line      = 1'b1;
   logic       out_q     = 1'b1;
   logic [7:0] low_ticks = 8'h00;

   // bus level seen by the block
   assign serial_in_pin_out = line;

   // bit ticks seen while the block holds a break on its output
   always @(posedge clk_sys_in) begin
      out_q <= serial_out_pin_in;
      if (!serial_out_pin_in && out_q) begin
         low_ticks <= 8'(baud_tick_in);
      end else if (!serial_out_pin_in && baud_tick_in) begin
         low_ticks <= low_ticks + 8'h01;
      end
   end

   // drive the bus low for n bit periods, then release it
   task automatic send_break(input int n);
      @(posedge clk_sys_in);
      #1;
      line = 1'b0;
      repeat (n) begin
         do @(posedge clk_sys_in); while (baud_tick_in !== 1'b1);
      end
      #1;
      line = 1'b1;
   endtask
endmodule

// [dv/lbfuc_tb.sv]
// Purpose: self-checking bench for the lin break control block
// Assumes: baud tick every 8 clocks, lin node model on the rx pin
// Notes:   reads and tx breaks queue their expected results
`timescale 1ns/1ps
module testbench;
   import lbfuc_pkg::*;
   ////////////////////////////////////////////////////////////////////
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [15:0] addr = 16'h0000;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [7:0]  wdata = 8'h00;
   logic [7:0]  rdata;
   logic        power = 1'b0;
   logic        txe = 1'b0;
   logic        rxe = 1'b0;
   logic        tick = 1'b0;
   logic [2:0]  tick_cnt = 3'h0;
   logic        frame_bit = 1'b1;
   logic        irq0_pin = 1'b0;
   logic        cap_pin = 1'b0;
   logic        rx_line, tx_line, irq0_o, cap_o, first_o;
   logic        tx_busy, tx_done, rx_done, rx_err;
   logic [7:0]  oe;
   logic [7:0]  rd_q[$];
   logic [7:0]  tx_q[$];
   // break length in bit periods for each length code 0 to 7
   logic [7:0]  len_tab[8] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14,
                               8'h0D, 8'h0E, 8'h0F};
   logic        rd_seen = 1'b0;
   logic [31:0] rnd = 32'h3D;
   int          n_fail = 0;
   int          num_checks = 0;

   // clock and one-cycle baud tick every 8 clocks
   always #25 clk = ~clk;
   always @(posedge clk) begin
      tick <= (tick_cnt == 3'h7);
      tick_cnt <= tick_cnt + 3'h1;
   end

   lbfuc_ctrl DUT (.clk_sys_in(clk), .sys_rst_in(rst), .clk_en_in(1'b1),
      .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_wdata_in(wdata), .reg_rdata_out(rdata),
      .unit_power_in(power), .tx_enable_bit_in(txe),
      .rx_enable_bit_in(rxe), .baud_tick_in(tick),
      .tx_frame_bit_in(frame_bit), .serial_in_pin_in(rx_line),
      .irq0_pin_in(irq0_pin), .capture_pin_in(cap_pin),
      .serial_out_pin_out(tx_line), .port4_oe_out(oe),
      .ext_irq0_input_out(irq0_o), .timer_capture_input_out(cap_o),
      .first_bit_sel_out(first_o), .break_tx_busy_out(tx_busy),
      .break_tx_done_out(tx_done), .break_rx_done_out(rx_done),
      .break_rx_error_out(rx_err));

   lbfuc_lin_node node (.clk_sys_in(clk), .baud_tick_in(tick),
      .serial_out_pin_in(tx_line), .serial_in_pin_out(rx_line));

   ////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic chk(input string what, input logic [7:0] seen,
                      input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // one register write, or one read whose expected value is queued
   task automatic acc(input bit w, input logic [15:0] a,
                      input logic [7:0] d);
      if (!w) rd_q.push_back(d);
      @(posedge clk);
      #1;
      addr = a;
      wdata = d;
      wr = w;
      rd = !w;
      @(posedge clk);
      #1;
      wr = 1'b0;
      rd = 1'b0;
   endtask

   // bounded wait: 0 tx done, 1 rx done, 2 rx error, 3 baud tick
   task automatic wait_hi(input int sel);
      for (int i = 0; i < 400; i++) begin
         @(posedge clk);
         if ((sel == 0 ? tx_done : sel == 1 ? rx_done :
              sel == 2 ? rx_err : tick) === 1'b1) return;
      end
      n_fail++;
      $display("Error wait %0d expected pulse seen none", sel);
      report_and_stop();
   endtask

   // watcher: compares read data and break lengths to queued notes
   always @(posedge clk) begin
      if (rd_seen) chk("read data", rdata, rd_q.pop_front());
      if (tx_done === 1'b1) chk("break bits", node.low_ticks,
                                tx_q.pop_front());
      rd_seen = rd;
   end

   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge clk);
      #1;
      rst = 1'b0;
      chk("oe", oe, 8'h00);
      acc(0, OFS_BREAK_CTRL, 8'h16);
      acc(0, OFS_PORT4_DIR, 8'hFF);
      acc(0, OFS_INPUT_ROUTE, 8'h00);
      acc(0, 16'h1234, 8'h00);
      // port 4 direction with random values
      for (int i = 0; i < 4; i++) begin
         rnd = xs(rnd);
         acc(1, OFS_PORT4_DIR, rnd[7:0]);
         acc(0, OFS_PORT4_DIR, rnd[7:0]);
         chk("oe", oe, ~rnd[7:0]);
      end
      acc(1, OFS_PORT4_DIR, 8'hF7);
      // input routing, every select code, random pin levels
      for (int r = 0; r < 4; r++) begin
         acc(1, OFS_INPUT_ROUTE, 8'(r));
         acc(0, OFS_INPUT_ROUTE, 8'(r));
         for (int k = 0; k < 3; k++) begin
            rnd = xs(rnd);
            {node.line, irq0_pin, cap_pin} = rnd[2:0];
            repeat (5) @(posedge clk);
            #1;
            chk("irq0", 8'(irq0_o), 8'(r[0] ? rx_line : irq0_pin));
            chk("capture", 8'(cap_o), 8'(r[1] ? rx_line : cap_pin));
         end
      end
      node.line = 1'b1;
      // bit order and inversion, enables off while changing them
      power = 1'b1;
      for (int v = 0; v < 4; v++) begin
         acc(1, OFS_BREAK_CTRL, 8'h14 | 8'(v));
         for (int f = 0; f < 2; f++) begin
            frame_bit = f[0];
            repeat (3) @(posedge clk);
            #1;
            chk("first bit", 8'(first_o), 8'(v[1]));
            chk("tx pin", 8'(tx_line), 8'(f[0] ^ v[0]));
         end
      end
      frame_bit = 1'b1;
      acc(1, OFS_BREAK_CTRL, 8'h16);
      // break transmission for every length code, refreshed mid-break
      txe = 1'b1;
      for (int c = 0; c < 8; c++) begin
         wait_hi(3);
         tx_q.push_back(len_tab[c]);
         acc(1, OFS_BREAK_CTRL, 8'h22 | 8'(c << 2));
         acc(1, OFS_BREAK_CTRL, 8'h02 | 8'(c << 2));
         acc(0, OFS_BREAK_CTRL, 8'h02 | 8'(c << 2));
         chk("tx busy", 8'(tx_busy), 8'h01);
         wait_hi(0);
         repeat (2) @(posedge clk);
         #1;
         chk("tx idle", 8'(tx_line), 8'h01);
         chk("tx busy", 8'(tx_busy), 8'h00);
      end
      // break reception: good, too short, rearm, good again
      rxe = 1'b1;
      acc(1, OFS_BREAK_CTRL, 8'h56);
      acc(0, OFS_BREAK_CTRL, 8'h96);
      node.send_break(12);
      wait_hi(1);
      acc(0, OFS_BREAK_CTRL, 8'h16);
      acc(1, OFS_BREAK_CTRL, 8'h56);
      node.send_break(5);
      wait_hi(2);
      acc(0, OFS_BREAK_CTRL, 8'h96);
      acc(1, OFS_BREAK_CTRL, 8'h56);
      node.send_break(13);
      wait_hi(1);
      acc(0, OFS_BREAK_CTRL, 8'h16);
      // reception armed, then enables off, power off and a refused trigger
      acc(1, OFS_BREAK_CTRL, 8'h56);
      acc(0, OFS_BREAK_CTRL, 8'h96);
      rxe = 1'b0;
      txe = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      power = 1'b0;
      acc(0, OFS_BREAK_CTRL, 8'h16);
      acc(1, OFS_BREAK_CTRL, 8'h56);
      acc(0, OFS_BREAK_CTRL, 8'h16);
      repeat (2) @(posedge clk);
      report_and_stop();
   end
endmodule
